// ==== logic/crc_cfg.svh ====
`ifndef CRC_CFG_SVH
`define CRC_CFG_SVH

// Register offsets (word index on the plain register port)
`define CRC_ADDR_CTRL 4'h0
`define CRC_ADDR_WCOUNT 4'h1
`define CRC_ADDR_STATUS 4'h2
`define CRC_ADDR_INT_STAT 4'h3
`define CRC_ADDR_INT_MASK 4'h4

// Control register fields
`define CRC_CTRL_GO 0
`define CRC_CTRL_BIN 1

// Interrupt status bit positions
`define CRC_INT_CEZ 0
`define CRC_INT_VALID 1
`define CRC_INT_PARITY 2
`define CRC_INT_CARD 3
`define CRC_INT_NRDY 4

// Card geometry and channel packing
`define CRC_LAST_COL 7'h50
`define CRC_LAST_CPW 2'h3
`define CRC_CEZ_LEVEL 5'h1F

// Reset values
`define CRC_INT_MASK_RST 5'h00
`define CRC_WCOUNT_RST 12'h000

`endif

// ==== logic/crc_pkg.sv ====
package crc_pkg;

    // Gray codes along idle, wait, first, second
    typedef enum logic [2:0] {
        CRC_IDLE = 3'h0,
        CRC_COLW = 3'h1,
        CRC_SENDA = 3'h3,
        CRC_SENDB = 3'h2,
        CRC_DISC = 3'h6
    } crc_state_e;

    // Whole state of the coupler
    typedef struct packed {
        crc_state_e st;
        logic bin;
        logic [6:0] col;
        logic [11:0] colbuf;
        logic [5:0] chr;
        logic cval;
        logic cerr;
        logic [1:0] cpw;
        logic [11:0] wcnt;
        logic conn;
        logic ready;
        logic eof;
        logic lamp;
        logic feed;
        logic [4:0] ist;
        logic [4:0] imask;
        logic [15:0] rdata;
        logic [5:0] s1;
        logic [5:0] s2;
        logic start_prev;
        logic col_prev;
        logic [11:0] d1;
        logic [11:0] d2;
    } crc_state_s;

endpackage : crc_pkg

// ==== logic/crc_coupler.sv ====
`timescale 1ns/1ps
`include "crc_cfg.svh"

// Behaviour
// - Hollerith mode turns each column into one 6-bit character for the channel.
// - Binary mode sends each column as two untranslated 6-bit characters.
// - Binary first character is rows 12 to 3, second rows 4 to 9.
// - Binary mode packs two columns into one four-character channel word.
// - Columns go out in ascending order, upper character before lower.
// - A card yields 80 characters in Hollerith mode, 160 in binary.
// - Hollerith column outside the 64 legal patterns raises a validity check.
// - Validity check flags the channel character and lights the validity lamp.
// - Ready needs power, cards in hopper and an operator start.
// - Full stacker or empty hopper drops ready and lights not-ready lamp.
// - After dropping, ready returns only on a new start with fault gone.
// - After the last card, end-of-file sets if the end-of-file switch is on.
// - Word count reaching zero raises its interrupt, then disconnects the unit.
// - The count-equals-zero interrupt is signalled on level 31.
// - A channel parity error is recorded for a later channel error test.
// - End-of-file holds until cards are added or the switch goes off.
module crc_coupler
    import crc_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    // Register port
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    // Mechanism pins
    input wire logic mech_power_ok,
    input wire logic mech_hopper_loaded,
    input wire logic mech_stacker_full,
    input wire logic mech_start_btn,
    input wire logic mech_eof_switch,
    input wire logic mech_col_strobe,
    input wire logic [11:0] mech_col_data,
    output logic mech_feed_card,
    output logic not_ready_lamp,
    output logic validity_lamp,
    // Channel side
    output logic [5:0] chan_char,
    output logic chan_valid,
    output logic chan_err,
    input wire logic chan_ready,
    output logic chan_connected,
    input wire logic chan_parity_err,
    output logic [4:0] chan_int_level,
    output logic irq
);

    // Hollerith column to internal code; bit 6 marks a legal pattern
    function automatic logic [6:0] crc_translate(input logic [11:0] c);
        logic [1:0] zone;
        logic [3:0] dig;
        logic ok;
        logic [8:0] d;
        zone = 2'h0;
        dig = 4'h0;
        ok = 1'b1;
        d = c[8:0];
        // Rows 12, 11, 0 are zones; at most one may be punched
        case (c[11:9])
            3'h0: zone = 2'h0;
            3'h4: zone = 2'h1;
            3'h2: zone = 2'h2;
            3'h1: zone = 2'h3;
            default: ok = 1'b0;
        endcase
        // Rows 1..9 alone, or row 8 with one of rows 2..7
        case (d)
            9'h000: dig = 4'h0;
            9'h100: dig = 4'h1;
            9'h080: dig = 4'h2;
            9'h040: dig = 4'h3;
            9'h020: dig = 4'h4;
            9'h010: dig = 4'h5;
            9'h008: dig = 4'h6;
            9'h004: dig = 4'h7;
            9'h002: dig = 4'h8;
            9'h001: dig = 4'h9;
            9'h082: dig = 4'hA;
            9'h042: dig = 4'hB;
            9'h022: dig = 4'hC;
            9'h012: dig = 4'hD;
            9'h00A: dig = 4'hE;
            9'h006: dig = 4'hF;
            default: ok = 1'b0;
        endcase
        return {ok, zone, dig};
    endfunction : crc_translate

    crc_state_s s_r;
    crc_state_s s_nxt;

    // Synchronised pin views; only second stage is read
    logic pwr;
    logic hop;
    logic stk;
    logic eof_sw;
    logic start_edge;
    logic col_edge;
    logic fault;
    logic accept;
    logic cez_hit;
    logic card_end;
    logic [6:0] tr;
    logic [4:0] ev;
    logic [4:0] clr;

    assign pwr = s_r.s2[0];
    assign hop = s_r.s2[1];
    assign stk = s_r.s2[2];
    assign eof_sw = s_r.s2[4];
    assign start_edge = s_r.s2[3] & ~s_r.start_prev;
    assign col_edge = s_r.s2[5] & ~s_r.col_prev;
    assign fault = ~pwr | ~hop | stk;
    assign accept = s_r.cval & chan_ready;
    // Fourth character of a word with one word left ends the transfer
    assign cez_hit = accept && (s_r.cpw == `CRC_LAST_CPW) && (s_r.wcnt == 12'h001);
    assign card_end = (s_r.col == `CRC_LAST_COL);
    assign tr = crc_translate(s_r.d2);

    // Next-state logic for the whole coupler
    always_comb begin
        s_nxt = s_r;
        ev = 5'h00;
        clr = 5'h00;
        s_nxt.feed = 1'b0;
        s_nxt.rdata = 16'h0000;
        // Two-stage pin synchronisers; data bus changes before its strobe
        s_nxt.s1 = {mech_col_strobe, mech_eof_switch, mech_start_btn,
                    mech_stacker_full, mech_hopper_loaded, mech_power_ok};
        s_nxt.s2 = s_r.s1;
        s_nxt.d1 = mech_col_data;
        s_nxt.d2 = s_r.d1;
        s_nxt.start_prev = s_r.s2[3];
        s_nxt.col_prev = s_r.s2[5];

        // Ready latch: a fault drops it, only a fresh start raises it
        if (fault) begin
            s_nxt.ready = 1'b0;
            ev[`CRC_INT_NRDY] = s_r.ready;
        end else if (start_edge) begin
            s_nxt.ready = 1'b1;
        end

        // End-of-file holds until cards come back or the switch is off
        if (hop || !eof_sw) begin
            s_nxt.eof = 1'b0;
        end

        // Channel word count is loaded by the parallel output transfer
        if (reg_wr && reg_addr == `CRC_ADDR_WCOUNT) begin
            s_nxt.wcnt = reg_wdata[11:0];
        end

        // Transfer sequencer
        case (s_r.st)
            CRC_IDLE: begin
                // Start is ignored unless ready, so software must test first
                if (reg_wr && reg_addr == `CRC_ADDR_CTRL && reg_wdata[`CRC_CTRL_GO]
                    && s_r.ready) begin
                    s_nxt.bin = reg_wdata[`CRC_CTRL_BIN];
                    s_nxt.col = 7'h00;
                    s_nxt.cpw = 2'h0;
                    s_nxt.conn = 1'b1;
                    s_nxt.feed = 1'b1;
                    s_nxt.lamp = 1'b0;
                    s_nxt.st = CRC_COLW;
                end
            end
            CRC_COLW: begin
                // Columns arrive one by one from the first onward
                if (col_edge) begin
                    s_nxt.colbuf = s_r.d2;
                    s_nxt.col = s_r.col + 7'h01;
                    s_nxt.cval = 1'b1;
                    s_nxt.st = CRC_SENDA;
                    if (s_r.bin) begin
                        s_nxt.chr = s_r.d2[11:6];
                        s_nxt.cerr = 1'b0;
                    end else begin
                        s_nxt.chr = tr[5:0];
                        s_nxt.cerr = ~tr[6];
                        if (!tr[6]) begin
                            s_nxt.lamp = 1'b1;
                            ev[`CRC_INT_VALID] = 1'b1;
                        end
                    end
                end
            end
            CRC_SENDA, CRC_SENDB: begin
                // Character stands until the channel takes it
                if (accept) begin
                    s_nxt.cpw = s_r.cpw + 2'h1;
                    s_nxt.cval = 1'b0;
                    s_nxt.cerr = 1'b0;
                    if (s_r.cpw == `CRC_LAST_CPW) begin
                        s_nxt.wcnt = s_r.wcnt - 12'h001;
                    end
                    if (cez_hit) begin
                        ev[`CRC_INT_CEZ] = 1'b1;
                        s_nxt.st = CRC_DISC;
                    end else if (s_r.st == CRC_SENDA && s_r.bin) begin
                        s_nxt.chr = s_r.colbuf[5:0];
                        s_nxt.cval = 1'b1;
                        s_nxt.st = CRC_SENDB;
                    end else begin
                        s_nxt.st = CRC_COLW;
                    end
                    // Last character of column 80 ends the card even when the
                    // word count runs out on that same character
                    if (card_end && !(s_r.st == CRC_SENDA && s_r.bin)) begin
                        // 80 columns give 80 or 160 characters
                        ev[`CRC_INT_CARD] = 1'b1;
                        s_nxt.st = CRC_DISC;
                        if (!hop && eof_sw) begin
                            s_nxt.eof = 1'b1;
                        end
                    end
                end
            end
            CRC_DISC: begin
                // Disconnect one cycle after the interrupt is raised
                s_nxt.conn = 1'b0;
                s_nxt.st = CRC_IDLE;
            end
            default: begin
                s_nxt.st = CRC_IDLE;
            end
        endcase

        // Channel parity errors are kept for the channel error test
        ev[`CRC_INT_PARITY] = chan_parity_err;

        // Mask and write-one-to-clear status
        if (reg_wr && reg_addr == `CRC_ADDR_INT_MASK) begin
            s_nxt.imask = reg_wdata[4:0];
        end
        if (reg_wr && reg_addr == `CRC_ADDR_INT_STAT) begin
            clr = reg_wdata[4:0];
        end
        // A new event beats a clear in the same cycle
        s_nxt.ist = (s_r.ist & ~clr) | ev;

        // Read decode; unmapped addresses read zero
        if (reg_rd) begin
            if (reg_addr == `CRC_ADDR_WCOUNT) begin
                s_nxt.rdata = {4'h0, s_r.wcnt};
            end else if (reg_addr == `CRC_ADDR_STATUS) begin
                s_nxt.rdata = {4'h0, s_r.col, s_r.bin, s_r.conn, s_r.lamp,
                               s_r.eof, s_r.ready};
            end else if (reg_addr == `CRC_ADDR_INT_STAT) begin
                s_nxt.rdata = {11'h000, s_r.ist};
            end else if (reg_addr == `CRC_ADDR_INT_MASK) begin
                s_nxt.rdata = {11'h000, s_r.imask};
            end
        end
    end

    // Single state register
    always_ff @(posedge core_clk) begin
        if (rst) begin
            s_r <= '0;
            s_r.st <= CRC_IDLE;
            s_r.wcnt <= `CRC_WCOUNT_RST;
            s_r.imask <= `CRC_INT_MASK_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Outputs from the state register, except the interrupt level, which is a constant
    assign reg_rdata = s_r.rdata;
    assign mech_feed_card = s_r.feed;
    assign not_ready_lamp = ~s_r.ready;
    assign validity_lamp = s_r.lamp;
    assign chan_char = s_r.chr;
    assign chan_valid = s_r.cval;
    assign chan_err = s_r.cerr;
    assign chan_connected = s_r.conn;
    assign chan_int_level = `CRC_CEZ_LEVEL;
    assign irq = |(s_r.ist & s_r.imask);

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    hold_char_a: assert property (
        chan_valid && !chan_ready |=> chan_valid && $stable(chan_char) && $stable(chan_err))
        else $error("character changed before acceptance");

    bin_upper_a: assert property (
        s_r.st == CRC_COLW && col_edge && s_r.bin |=> chan_char == $past(s_r.d2[11:6]))
        else $error("binary first character not upper rows");

    bin_lower_a: assert property (
        s_r.st == CRC_SENDA && s_r.bin && accept && !cez_hit
        |=> s_r.st == CRC_SENDB && chan_valid && chan_char == $past(s_r.colbuf[5:0]))
        else $error("binary second character wrong");

    err_lamp_a: assert property (
        chan_valid && chan_err |-> validity_lamp && !s_r.bin)
        else $error("validity error without lamp");

    start_needed_a: assert property (
        !s_r.ready && !start_edge |=> !s_r.ready)
        else $error("ready rose without start");

    fault_drop_a: assert property (
        s_r.ready && fault |=> !s_r.ready && not_ready_lamp)
        else $error("ready held during fault");

    eof_hold_a: assert property (
        s_r.eof && !hop && eof_sw |=> s_r.eof)
        else $error("end-of-file dropped early");

    cez_order_a: assert property (
        cez_hit |=> s_r.ist[`CRC_INT_CEZ] && chan_connected ##1 !chan_connected)
        else $error("count zero order wrong");

    parity_rec_a: assert property (
        chan_parity_err |=> s_r.ist[`CRC_INT_PARITY])
        else $error("parity error not recorded");

    card_len_a: assert property (
        $rose(s_r.ist[`CRC_INT_CARD]) |-> $past(s_r.col) == `CRC_LAST_COL)
        else $error("card ended at wrong column");

    start_ready_a: assert property (
        mech_feed_card |-> $past(s_r.ready))
        else $error("card fed while not ready");

    zone_check_a: assert property (
        s_r.st == CRC_COLW && col_edge && !s_r.bin && $countones(s_r.d2[11:9]) > 1
        |=> chan_err)
        else $error("double zone punch not flagged");

    lamp_set_a: assert property (
        s_r.st == CRC_COLW && col_edge && !s_r.bin && !tr[6] |=> validity_lamp && chan_err)
        else $error("validity check without lamp");

    hol_single_a: assert property (
        chan_valid && !s_r.bin |-> s_r.st == CRC_SENDA)
        else $error("second character in Hollerith mode");

    col_range_a: assert property (
        s_r.col <= `CRC_LAST_COL)
        else $error("column count past last column");

    word_count_a: assert property (
        accept && s_r.cpw == `CRC_LAST_CPW && !(reg_wr && reg_addr == `CRC_ADDR_WCOUNT)
        |=> s_r.wcnt == $past(s_r.wcnt) - 12'h001)
        else $error("word count not stepped");

    eof_set_a: assert property (
        accept && card_end && !(s_r.st == CRC_SENDA && s_r.bin) && !hop && eof_sw
        |=> s_r.eof)
        else $error("end-of-file not set");

    eof_clear_a: assert property (
        hop || !eof_sw |=> !s_r.eof)
        else $error("end-of-file held after cards or switch off");

    ready_rise_a: assert property (
        $rose(s_r.ready) |-> $past(start_edge) && !$past(fault))
        else $error("ready rose without start and clear fault");

    nrdy_event_a: assert property (
        s_r.ready && fault |=> s_r.ist[`CRC_INT_NRDY])
        else $error("ready drop not recorded");

    hol_card_c: cover property (s_r.st == CRC_DISC && !s_r.bin && !s_r.ist[0]);
    bin_card_c: cover property (s_r.st == CRC_SENDB && accept && card_end);
    cez_c: cover property (cez_hit);
    valid_c: cover property (chan_valid && chan_err);

endmodule : crc_coupler

// ==== sim/crc_chan_model.sv ====
`timescale 1ns/1ps

// Channel stand-in: takes characters, stalls on request, reports parity faults
module crc_chan_model (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic stall,
    input wire logic par_go,
    output logic chan_ready,
    output logic chan_parity_err
);
    logic [1:0] cnt_r;

    // A stalled channel accepts one cycle in four, so held characters are exercised
    always_ff @(posedge core_clk) begin
        if (rst) begin
            cnt_r <= 2'h0;
            chan_ready <= 1'b0;
            chan_parity_err <= 1'b0;
        end else begin
            cnt_r <= cnt_r + 2'h1;
            chan_ready <= !stall || (cnt_r == 2'h3);
            chan_parity_err <= par_go; // One-cycle fault pulse
        end
    end
endmodule : crc_chan_model

// ==== sim/test_card_reader_coupler.sv ====
`timescale 1ns/1ps
`include "crc_cfg.svh"

module test_card_reader_coupler;
    logic core_clk = 1'b0;
    logic rst, reg_wr, reg_rd, pwr, hop, stk, sbtn, eofsw, cstb, feed, nrl, vlamp;
    logic cv, cerr, crdy, conn, perr, irq, stall, par_go, rd_p;
    logic [3:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata, lf;
    logic [11:0] cdat;
    logic [5:0] cch;
    logic [4:0] ilvl;
    logic [13:0] chq[$];
    logic [31:0] rq[$];
    int n_errors, comparisons, n_acc, n_feed;

    crc_coupler dut (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .mech_power_ok(pwr), .mech_hopper_loaded(hop), .mech_stacker_full(stk),
        .mech_start_btn(sbtn), .mech_eof_switch(eofsw), .mech_col_strobe(cstb),
        .mech_col_data(cdat), .mech_feed_card(feed), .not_ready_lamp(nrl),
        .validity_lamp(vlamp), .chan_char(cch), .chan_valid(cv), .chan_err(cerr),
        .chan_ready(crdy), .chan_connected(conn), .chan_parity_err(perr),
        .chan_int_level(ilvl), .irq(irq));
    crc_chan_model chan (.core_clk(core_clk), .rst(rst), .stall(stall), .par_go(par_go),
        .chan_ready(crdy), .chan_parity_err(perr));

    // Free-running bench clock at 50 MHz
    always #10 core_clk = ~core_clk;

    function automatic logic [15:0] nxt(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction : nxt

    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
        comparisons++;
        if (s !== e) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
        end
    endtask : chk

    task automatic end_of_test();
        $display("counts: %0d comparisons, %0d mismatches", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : end_of_test

    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask : cyc

    // Idle cycle after the strobe, so a following write never re-drives it in one step
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        cyc(1);
        reg_wr <= 1'b0;
        cyc(1);
    endtask : wr

    // Extra idle cycle keeps reg_rd from being driven twice in one time step
    task automatic rd(input logic [3:0] a, input logic [15:0] e, input logic [15:0] m);
        rq.push_back({m, e & m});
        reg_addr <= a;
        reg_rd <= 1'b1;
        cyc(1);
        reg_rd <= 1'b0;
        cyc(1);
    endtask : rd

    task automatic press();
        sbtn <= 1'b1;
        cyc(6);
        sbtn <= 1'b0;
        cyc(6);
    endtask : press

    // Data stands well ahead of the strobe because the pins pass a synchroniser
    task automatic col(input logic [11:0] d, input int k);
        int t;
        t = n_acc + k;
        cdat <= d;
        stall <= lf[3];
        cyc(4);
        cstb <= 1'b1;
        for (int i = 0; i < 300 && n_acc < t; i++) cyc(1);
        if (n_acc < t) begin
            n_errors++;
            $display("[FAIL] column chars expected %0d seen %0d", t, n_acc);
            end_of_test();
        end
        cstb <= 1'b0;
        cyc(4);
    endtask : col

    // Notes each expected character as {mask, value} and feeds the columns
    task automatic card(input logic bin, input int n, input logic drop);
        logic [11:0] d;
        int z, dg;
        n_acc = 0;
        for (int i = 0; i < n; i++) begin
            lf = nxt(lf);
            z = lf[5:4] % 3;
            dg = 1 + lf[15:8] % 9;
            if (bin) d = lf[11:0];
            else if (i % 7 == 5) d = 12'h180;
            else d = (z == 1 ? 12'h800 : z == 2 ? 12'h400 : 12'h0) | (12'h1 << (9 - dg));
            if (bin) chq.push_back({7'h7f, 1'b0, d[11:6]});
            if (bin) chq.push_back({7'h7f, 1'b0, d[5:0]});
            else if (i % 7 == 5) chq.push_back({7'h40, 7'h40});
            else chq.push_back({7'h7f, 1'b0, 6'(z * 16 + dg)});
            if (drop && i == n - 1) hop <= 1'b0;
            col(d, bin ? 2 : 1);
        end
        cyc(8);
    endtask : card

    // Takes the oldest note at each accepted character and each read answer
    always @(posedge core_clk) begin
        logic [13:0] q;
        logic [31:0] r;
        if (!rst && cv === 1'b1 && crdy === 1'b1) begin
            n_acc++;
            q = (chq.size() > 0) ? chq.pop_front() : 14'h3fff;
            chk("chan char", {9'h0, q[6:0]}, {9'h0, q[13:7] & {cerr, cch}});
        end
        if (!rst && feed === 1'b1) n_feed++;
        if (rd_p) begin
            r = (rq.size() > 0) ? rq.pop_front() : 32'hffff_ffff;
            chk("reg read", r[15:0], reg_rdata & r[31:16]);
        end
        rd_p = reg_rd;
    end

    initial begin
        {n_errors, comparisons, n_acc, n_feed} = '0;
        {reg_wr, reg_rd, pwr, hop, stk, sbtn, eofsw, cstb, stall, par_go, rd_p} = '0;
        {reg_addr, reg_wdata, cdat} = '0;
        lf = 16'h78b5;
        rst = 1'b1;
        cyc(12);
        rst <= 1'b0;
        cyc(1);
        chk("not ready lamp", 16'h1, {15'h0, nrl});
        chk("int level", 16'h1f, {11'h0, ilvl});
        rd(`CRC_ADDR_STATUS, 16'h0, 16'h001f);
        rd(`CRC_ADDR_INT_MASK, 16'h0, 16'hffff);
        rd(4'h9, 16'h0, 16'hffff);
        $display("test reset done");
        pwr <= 1'b1;
        hop <= 1'b1;
        cyc(8);
        rd(`CRC_ADDR_STATUS, 16'h0, 16'h0001);
        press();
        rd(`CRC_ADDR_STATUS, 16'h1, 16'h0001);
        chk("not ready lamp", 16'h0, {15'h0, nrl});
        $display("test ready done");
        wr(`CRC_ADDR_INT_MASK, 16'h001f);
        wr(`CRC_ADDR_WCOUNT, 16'h0028);
        wr(`CRC_ADDR_CTRL, 16'h0003);
        card(1'b1, 80, 1'b0);
        chk("binary count", 16'd160, 16'(n_acc));
        rd(`CRC_ADDR_INT_STAT, 16'h0009, 16'h0009);
        chk("irq", 16'h1, {15'h0, irq});
        chk("connected", 16'h0, {15'h0, conn});
        wr(`CRC_ADDR_INT_STAT, 16'h001f);
        cyc(2);
        chk("irq", 16'h0, {15'h0, irq});
        $display("test binary done");
        eofsw <= 1'b1;
        wr(`CRC_ADDR_WCOUNT, 16'h0000);
        rd(`CRC_ADDR_STATUS, 16'h0001, 16'h0001);
        wr(`CRC_ADDR_CTRL, 16'h0001);
        card(1'b0, 80, 1'b1);
        chk("hollerith count", 16'd80, 16'(n_acc));
        rd(`CRC_ADDR_STATUS, 16'h0006, 16'h0007);
        chk("validity lamp", 16'h1, {15'h0, vlamp});
        chk("not ready lamp", 16'h1, {15'h0, nrl});
        rd(`CRC_ADDR_INT_STAT, 16'h001a, 16'h001a);
        wr(`CRC_ADDR_INT_STAT, 16'h001f);
        $display("test hollerith done");
        hop <= 1'b1;
        cyc(8);
        rd(`CRC_ADDR_STATUS, 16'h0000, 16'h0003);
        press();
        rd(`CRC_ADDR_STATUS, 16'h0005, 16'h0007);
        stk <= 1'b1;
        cyc(8);
        rd(`CRC_ADDR_STATUS, 16'h0000, 16'h0001);
        stk <= 1'b0;
        cyc(8);
        rd(`CRC_ADDR_STATUS, 16'h0000, 16'h0001);
        press();
        par_go <= 1'b1;
        cyc(1);
        par_go <= 1'b0;
        cyc(3);
        rd(`CRC_ADDR_INT_STAT, 16'h0004, 16'h0004);
        $display("test faults done");
        wr(`CRC_ADDR_INT_STAT, 16'h001f);
        wr(`CRC_ADDR_WCOUNT, 16'h0001);
        rd(`CRC_ADDR_STATUS, 16'h0001, 16'h0001);
        wr(`CRC_ADDR_CTRL, 16'h0003);
        card(1'b1, 2, 1'b0);
        chk("validity lamp", 16'h0, {15'h0, vlamp});
        rd(`CRC_ADDR_INT_STAT, 16'h0001, 16'h0001);
        chk("connected", 16'h0, {15'h0, conn});
        cyc(2);
        chk("feed count", 16'd3, 16'(n_feed));
        chk("notes left", 16'h0, 16'(chq.size() + rq.size()));
        $display("test count zero done");
        end_of_test();
    end
endmodule : test_card_reader_coupler
